// ### rtl/pgr_ctrl.sv
// PLL clock gating and dynamic phase shift reconfiguration controller
module pgr_ctrl #(
    parameter int GATE_SYNC_STAGES = 2
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic mgmt_reset_i,
    input wire logic [pgr_pkg::ADDR_W-1:0] mgmt_address_i,
    input wire logic [pgr_pkg::DATA_W-1:0] mgmt_writedata_i,
    input wire logic mgmt_write_i,
    output logic [pgr_pkg::DATA_W-1:0] mgmt_readdata_o,
    output logic mgmt_waitrequest_o,
    output logic [pgr_pkg::DATA_W-1:0] clk_gate_en_o,
    output logic phase_en_o,
    output logic phase_updn_o,
    output logic [3:0] phase_cnt_sel_o,
    input wire logic phase_done_i
);
    import pgr_pkg::*;

    // Reset release through two flops; management reset acts as sync clear
    logic rst_meta;
    logic rst_sync_n;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // Phase done comes from the PLL domain, so it is synchronised first
    logic done_meta;
    logic done_sync;
    logic done_prev;
    logic done_rise;
    always_ff @(posedge clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            done_meta <= 1'b0;
            done_sync <= 1'b0;
            done_prev <= 1'b0;
        end else begin
            done_meta <= phase_done_i;
            done_sync <= done_meta;
            done_prev <= done_sync;
        end
    end

    pgr_state_t state, next_state;
    logic [DATA_W-1:0] gate_reg, next_gate_reg;
    logic [GATE_SYNC_STAGES*DATA_W-1:0] gate_pipe, next_gate_pipe;
    logic [STEPS_MSB-STEPS_LSB:0] steps, next_steps;
    logic updn, next_updn;
    logic [3:0] cnt_sel, next_cnt_sel;
    logic [2:0] timer, next_timer;
    logic step_en, next_step_en;
    logic done_seen, next_done_seen;
    logic [1:0] mode;
    logic gate_load;
    logic phase_load;

    assign mode = mgmt_address_i[MODE_MSB:MODE_LSB];
    // A phase write is taken only while idle
    assign phase_load = (state == PGR_IDLE) && mgmt_write_i && (mode == MODE_PHASE);

    // Only a fresh rise counts: done left high from the last step is stale
    assign done_rise = done_sync && !done_prev;

    // Next-state logic for the sequencer
    always_comb begin
        next_state = state;
        next_steps = steps;
        next_timer = timer;
        next_step_en = 1'b0;
        next_done_seen = done_seen;
        unique case (state)
            PGR_IDLE: begin
                // A write is taken only here, so writes under wait are ignored
                if (gate_load) begin
                    next_timer = 3'(GATE_WAIT_CYCLES);
                    next_state = PGR_GATE;
                end else if (phase_load) begin
                    next_steps = mgmt_writedata_i[STEPS_MSB:STEPS_LSB];
                    next_state = PGR_STEP;
                end
            end
            // Hold wait for the fixed gating span
            PGR_GATE: begin
                if (timer <= 3'h1) begin
                    next_state = PGR_IDLE;
                end else begin
                    next_timer = timer - 3'h1;
                end
            end
            PGR_STEP: begin
                // A step count of zero still issues one step
                next_step_en = 1'b1;
                next_done_seen = 1'b0;
                next_timer = 3'(STEP_GAP_CYCLES);
                next_state = PGR_WAIT_DONE;
            end
            PGR_WAIT_DONE: begin
                if (done_rise) begin
                    next_done_seen = 1'b1;
                end
                if (timer != 3'h0) begin
                    next_timer = timer - 3'h1;
                end
                if ((done_rise || done_seen) && timer == 3'h0) begin
                    next_state = PGR_GAP;
                end
            end
            // One cycle between steps, then the next step or back to idle
            PGR_GAP: begin
                if (steps <= 3'h1) begin
                    next_state = PGR_IDLE;
                end else begin
                    next_steps = steps - 3'h1;
                    next_state = PGR_STEP;
                end
            end
            default: next_state = PGR_IDLE;
        endcase
    end

    // Sequencer registers; management reset returns all to reset values
    always_ff @(posedge clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= PGR_IDLE;
            steps <= '0;
            timer <= 3'h0;
            step_en <= 1'b0;
            done_seen <= 1'b0;
        end else if (mgmt_reset_i) begin
            state <= PGR_IDLE;
            steps <= '0;
            timer <= 3'h0;
            step_en <= 1'b0;
            done_seen <= 1'b0;
        end else begin
            state <= next_state;
            steps <= next_steps;
            timer <= next_timer;
            step_en <= next_step_en;
            done_seen <= next_done_seen;
        end
    end

    // A gating write is taken only while idle
    assign gate_load = (state == PGR_IDLE) && mgmt_write_i && (mode == MODE_GATING);

    // Next values of the gate byte and its delay pipe
    always_comb begin
        next_gate_reg = gate_reg;
        if (gate_load) begin
            next_gate_reg = mgmt_writedata_i;
        end
        // Shift the byte in; the oldest stage drives the gate outputs
        next_gate_pipe = {gate_pipe[(GATE_SYNC_STAGES-1)*DATA_W-1:0], gate_reg};
    end

    // Gate registers; both resets leave every output clock running
    always_ff @(posedge clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            gate_reg <= GATE_RESET;
            gate_pipe <= {GATE_SYNC_STAGES{GATE_RESET}};
        end else if (mgmt_reset_i) begin
            gate_reg <= GATE_RESET;
            gate_pipe <= {GATE_SYNC_STAGES{GATE_RESET}};
        end else begin
            gate_reg <= next_gate_reg;
            gate_pipe <= next_gate_pipe;
        end
    end

    // Direction and counter select, held for the whole shift
    always_comb begin
        next_updn = updn;
        next_cnt_sel = cnt_sel;
        if (phase_load) begin
            next_updn = mgmt_writedata_i[DIR_BIT];
            next_cnt_sel = mgmt_writedata_i[CNT_MSB:CNT_LSB];
        end
    end

    // Phase setting registers
    always_ff @(posedge clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            updn <= 1'b0;
            cnt_sel <= 4'h0;
        end else if (mgmt_reset_i) begin
            updn <= 1'b0;
            cnt_sel <= 4'h0;
        end else begin
            updn <= next_updn;
            cnt_sel <= next_cnt_sel;
        end
    end

    // Wait is combinational so it rises in the cycle after the write
    assign mgmt_waitrequest_o = (state != PGR_IDLE) || mgmt_reset_i;
    // Pipe output lands as wait falls when GATE_SYNC_STAGES is 2, a cycle later per extra stage; the PLL may apply it later still
    assign clk_gate_en_o = gate_pipe[GATE_SYNC_STAGES*DATA_W-1 -: DATA_W];
    assign phase_en_o = step_en;
    assign phase_updn_o = updn;
    assign phase_cnt_sel_o = cnt_sel;
    assign mgmt_readdata_o = gate_reg;
endmodule

// ### rtl/pgr_pkg.sv
// Package of constants and types for the PLL gating and phase reconfiguration controller
package pgr_pkg;
    // Management port widths
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    // Mode field position and encodings in the management address
    localparam int MODE_MSB = 9;
    localparam int MODE_LSB = 8;
    localparam logic [1:0] MODE_STREAM = 2'h0;
    localparam logic [1:0] MODE_ADVANCED = 2'h1;
    localparam logic [1:0] MODE_GATING = 2'h2;
    localparam logic [1:0] MODE_PHASE = 2'h3;
    // Phase shift write-data layout: step count, direction, counter select
    localparam int STEPS_MSB = 2;
    localparam int STEPS_LSB = 0;
    localparam int DIR_BIT = 3;
    localparam int CNT_MSB = 7;
    localparam int CNT_LSB = 4;
    // Values after reset
    localparam logic [7:0] GATE_RESET = 8'hFF;
    // Cycles of wait held after a gating write
    localparam int GATE_WAIT_CYCLES = 2;
    // Cycles waited after each phase step before a done can end it; without done the wait never ends
    localparam int STEP_GAP_CYCLES = 4;
    typedef enum logic [2:0] {
        PGR_IDLE,
        PGR_GATE,
        PGR_STEP,
        PGR_WAIT_DONE,
        PGR_GAP
    } pgr_state_t;
endpackage

// ### sim/pgr_ctrl_asserts.sv
// Port assertions for the reconfiguration controller
module pgr_ctrl_asserts (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic mgmt_reset_i,
    input wire logic [9:0] mgmt_address_i,
    input wire logic [7:0] mgmt_writedata_i,
    input wire logic mgmt_write_i,
    input wire logic mgmt_waitrequest_o,
    input wire logic [7:0] clk_gate_en_o,
    input wire logic phase_en_o
);
    timeunit 1ns / 1ps;
    wire logic bsy = mgmt_waitrequest_o;
    default clocking @(posedge clk_i); endclocking
    // Management reset also forces wait, so it disables the write checks
    default disable iff (!resetn_i || mgmt_reset_i);
    // A write taken in mode m; one made under wait is refused
    sequence s_take(logic [1:0] m);
        mgmt_write_i && !bsy && mgmt_address_i[9:8] == m;
    endsequence
    AST_GATE_WAIT: assert property (s_take(2'h2) |=> bsy [*2] ##1 !bsy) else $error("wait");
    AST_GATE_OUT: assert property (s_take(2'h2) |-> ##3
        clk_gate_en_o == $past(mgmt_writedata_i, 3)) else $error("gate");
    AST_PHASE_EN: assert property (s_take(2'h3) |=> bsy ##1 phase_en_o) else $error("step");
    AST_EN_PULSE: assert property (phase_en_o |=> !phase_en_o) else $error("pulse");
    AST_PHASE_WAIT: assert property (phase_en_o |-> bsy [*5]) else $error("shift");
    AST_EN_BUSY: assert property (!bsy |-> !phase_en_o) else $error("idle");
    AST_OTHER_MODE: assert property (mgmt_write_i && !bsy && !mgmt_address_i[9] |=> !bsy)
        else $error("mode");
    AST_MRST: assert property (disable iff (!resetn_i) mgmt_reset_i |-> bsy)
        else $error("mrst");
endmodule
bind pgr_ctrl pgr_ctrl_asserts u_pgr_ctrl_asserts (.clk_i(clk_i), .resetn_i(resetn_i),
    .mgmt_reset_i(mgmt_reset_i), .mgmt_address_i(mgmt_address_i), .mgmt_write_i(mgmt_write_i),
    .mgmt_writedata_i(mgmt_writedata_i), .mgmt_waitrequest_o(mgmt_waitrequest_o),
    .clk_gate_en_o(clk_gate_en_o), .phase_en_o(phase_en_o));

// ### sim/pgr_pll_model.sv
// PLL side: done follows each phase step after a random delay
module pgr_pll_model (
    input wire logic clk_i,
    input wire logic step_i,
    output logic done_o = 1'b0
);
    timeunit 1ns / 1ps;
    int cnt = 0;
    // Done stays up until the next step, so a slow sampler cannot miss it
    always @(posedge clk_i) begin
        cnt <= step_i ? 1 + $urandom_range(0, 7) : (cnt > 0 ? cnt - 1 : 0);
        done_o <= !step_i && (done_o || cnt == 1);
    end
endmodule

// ### sim/tb_top.sv
// Self-checking bench for the reconfiguration controller
module tb_top;
    timeunit 1ns / 1ps;
    logic clk = 1'b0, rst_n = 1'b0, mrst = 1'b0, wr = 1'b0, done, bsy, en, updn;
    logic [9:0] adr = 10'h000;
    logic [7:0] wd = 8'h00, rd, gate;
    logic [3:0] sel;
    int n_errors = 0, checks_done = 0, eg = 255, eq[$];
    always #4 clk = ~clk;
    pgr_ctrl u_pgr_ctrl (.clk_i(clk), .resetn_i(rst_n), .mgmt_reset_i(mrst), .mgmt_address_i(adr),
        .mgmt_writedata_i(wd), .mgmt_write_i(wr), .mgmt_readdata_o(rd), .mgmt_waitrequest_o(bsy),
        .clk_gate_en_o(gate), .phase_en_o(en), .phase_updn_o(updn), .phase_cnt_sel_o(sel),
        .phase_done_i(done));
    pgr_pll_model u_pgr_pll_model (.clk_i(clk), .step_i(en), .done_o(done));
    task automatic chk(input logic ok, input string m);
        checks_done++;
        n_errors += (ok !== 1'b1);
        if (ok !== 1'b1) $display("[ERR] %0t %s", $time, m);
    endtask
    task automatic conclude();
        $display("errors %0d of %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Model first, then a one-cycle write; wait is followed under a bound
    task automatic op(input logic [9:0] a, input logic [7:0] d);
        if (a[9:8] == 2'h2) eg = d;
        if (a[9:8] == 2'h3) repeat ((d[2:0] == 3'h0) ? 1 : d[2:0]) eq.push_back({d[3], d[7:4]});
        adr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
        chk(bsy === a[9] && (a[9:8] != 2'h2 || rd === d), "accept");
        for (int n = 0; bsy === 1'b1 && n < 500; n++) begin
            if (en === 1'b1)
                chk(eq.size() > 0 && {updn, sel} === 5'(eq.pop_front()), "step");
            @(posedge clk);
        end
        chk(bsy === 1'b0 && eq.size() == 0 && gate === 8'(eg), "end");
    endtask
    initial begin
        #200000 n_errors++;
        conclude();
    end
    initial begin
        void'($urandom(30180));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        // Writes cycle through all four modes; stream and advanced must start nothing; recalibration stays outside
        for (int k = 0; k < 32; k++) op({2'(k), 8'($urandom)}, 8'($urandom));
        mrst <= 1'b1;
        @(posedge clk);
        chk(bsy === 1'b1, "mrst");
        mrst <= 1'b0;
        eg = 255;
        op(10'h300, 8'h00);
        conclude();
    end
endmodule
